// >>> shared/memmap_consts.vh
// address map constants for the core memory decoder
// Overview of operation
// - program counter is 13 bits, addressing 8k words of 14 bits
// - only program words 0000h to 07FFh physically exist
// - fetches above 2k wrap into the implemented 2k words
// - reset loads the program counter with 0000h
// - taking an interrupt loads the program counter with 0004h
// - data memory has two banks, each with special and general registers
// - lowest 32 locations of each bank are special function registers
// - general RAM answers at 20h-7Fh in bank 0, A0h-BFh in bank 1
// - bank 1 F0h-FFh reach the same cells as bank 0 70h-7Fh
// - unimplemented data locations read zero, writes are dropped
// - bank select bit 0 picks bank 0, 1 picks bank 1
`ifndef MEMMAP_CONSTS_VH
`define MEMMAP_CONSTS_VH
`define PC_WIDTH 13
`define PROG_AW 11
`define PROG_DW 14
`define RESET_VECTOR 13'h0000
`define INTR_VECTOR 13'h0004
`define SFA_TOP 8'h1F
`define B0_RAM_LO 8'h20
`define B0_RAM_HI 8'h7F
`define B1_RAM_LO 8'hA0
`define B1_RAM_HI 8'hBF
`define B1_MIRROR_LO 8'hF0
`define RAM_WORDS 128
`define RAM_AW 7
`define B1_RAM_BASE 7'h00
`endif

// >>> rtl/data_ram.v
// general purpose data RAM array, synchronous read and write
`timescale 1ns/1ps
module data_ram #(
  parameter AW = 7,
  parameter DEPTH = 128
) (
  // clock
  clk,
  // access
  we,
  addr,
  wdata,
  rdata
);
  input wire clk;
  input wire we;
  input wire [AW-1:0] addr;
  input wire [7:0] wdata;
  output reg [7:0] rdata;

  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    // write-first: a write answers with the byte it stores
    rdata <= we ? wdata : mem[addr];
  end
endmodule

// >>> rtl/mcu_memory_map_decode.v
// program counter and data address decoder for the 8-bit core
`timescale 1ns/1ps
`include "memmap_consts.vh"
module mcu_memory_map_decode (
  // clock and reset
  clk,
  rst,
  // program counter control from the core
  pc_step,
  pc_load,
  pc_load_value,
  intr_take,
  // program fetch address to the program array
  pc_q,
  prog_addr_q,
  // bank select state from the status register
  bank_select_bit,
  upper_bank_bit_reserved,
  indirect_bank_bit_reserved,
  // core data access
  data_req,
  data_we,
  data_operand,
  data_wdata,
  data_rdata_q,
  data_valid_q,
  // special function area port
  sfa_req_q,
  sfa_we_q,
  sfa_addr_q,
  sfa_wdata_q,
  sfa_rdata,
  // decode status of last access
  unimpl_hit_q
);
  // ==========================================
  // port declarations
  // clock and reset
  input wire clk;
  input wire rst;
  // program counter control
  input wire pc_step;
  input wire pc_load;
  input wire [12:0] pc_load_value;
  input wire intr_take;
  // program fetch address
  output reg [12:0] pc_q;
  output reg [10:0] prog_addr_q;
  // bank select state; the two reserved bits are left unread
  input wire bank_select_bit;
  input wire upper_bank_bit_reserved;
  input wire indirect_bank_bit_reserved;
  // core data access
  input wire data_req;
  input wire data_we;
  input wire [6:0] data_operand;
  input wire [7:0] data_wdata;
  output reg [7:0] data_rdata_q;
  output reg data_valid_q;
  // special function area port
  output reg sfa_req_q;
  output reg sfa_we_q;
  output reg [7:0] sfa_addr_q;
  output reg [7:0] sfa_wdata_q;
  input wire [7:0] sfa_rdata;
  // decode status
  output reg unimpl_hit_q;

  // ==========================================
  // program counter
  reg [12:0] pc_d;

  always @* begin
    pc_d = pc_q;
    // interrupt outranks a load, a load outranks a step
    // interrupt vector load
    if (intr_take) begin
      pc_d = `INTR_VECTOR;
    end else if (pc_load) begin
      pc_d = pc_load_value;
    end else if (pc_step) begin
      pc_d = pc_q + 13'h0001;
    end
  end

  // fetch address follows pc_d, so it never lags the counter
  always @(posedge clk) begin
    if (rst) begin
      pc_q <= `RESET_VECTOR;
      prog_addr_q <= 11'h000;
    end else begin
      pc_q <= pc_d;
      prog_addr_q <= pc_d[10:0];
    end
  end

  // ==========================================
  // data address decode
  // reserved upper bank bits are ignored; software keeps them zero
  wire [7:0] full_addr;
  wire in_sfa;
  wire in_b0_ram;
  wire in_b1_ram;
  wire in_mirror;
  wire in_hole;
  reg is_sfa;
  reg is_ram;
  reg [6:0] ram_index;

  assign full_addr = {bank_select_bit, data_operand};

  // ==========================================
  // region hits, mutually exclusive
  // special area per bank
  assign in_sfa = ({1'b0, data_operand} <= `SFA_TOP);
  assign in_b0_ram = (full_addr >= `B0_RAM_LO) && (full_addr <= `B0_RAM_HI);
  assign in_b1_ram = (full_addr >= `B1_RAM_LO) && (full_addr <= `B1_RAM_HI);
  // top of bank 1 reaches bank 0 cells
  assign in_mirror = (full_addr >= `B1_MIRROR_LO);
  // holes: only bank 1 C0h-EFh; bank 0 has none above the special area
  // whatever is left is a hole
  assign in_hole = ~(in_sfa | in_b0_ram | in_b1_ram | in_mirror);

  always @* begin
    is_sfa = in_sfa;
    // at most one region matches, so the or never mixes two hits
    is_ram = in_b0_ram | in_b1_ram | in_mirror;
    if (in_b1_ram) begin
      // bank 1 ram in the low words bank 0 leaves free
      ram_index = `B1_RAM_BASE + {2'b00, full_addr[4:0]};
    end else begin
      // bank 0 ram and the mirror share the low seven bits
      ram_index = full_addr[6:0];
    end
  end

  // ==========================================
  // ram array and response
  wire [7:0] ram_rdata;
  reg sel_ram_q;
  reg sel_sfa_q;
  reg pend_q;

  // one array holds both banks; the mirror adds no cells
  data_ram #(
    .AW(`RAM_AW),
    .DEPTH(`RAM_WORDS)
  ) u_ram (
    .clk(clk),
    .we(data_req & data_we & is_ram),
    .addr(ram_index),
    .wdata(data_wdata),
    .rdata(ram_rdata)
  );

  // ==========================================
  // forward to the special area, one-cycle pulse
  always @(posedge clk) begin
    if (rst) begin
      sfa_req_q <= 1'b0;
      sfa_we_q <= 1'b0;
      sfa_addr_q <= 8'h00;
      sfa_wdata_q <= 8'h00;
    end else begin
      sfa_req_q <= data_req & is_sfa;
      sfa_we_q <= data_req & data_we & is_sfa;
      // address and data ride along every cycle; only the pulse matters
      sfa_addr_q <= full_addr;
      sfa_wdata_q <= data_wdata;
    end
  end

  // ==========================================
  // request tracking for the answer stage
  always @(posedge clk) begin
    if (rst) begin
      sel_ram_q <= 1'b0;
      sel_sfa_q <= 1'b0;
      pend_q <= 1'b0;
      unimpl_hit_q <= 1'b0;
    end else begin
      sel_ram_q <= is_ram;
      sel_sfa_q <= is_sfa;
      // answer follows every request, hole or not
      pend_q <= data_req;
      // flag holds between requests so the core sees the last access
      if (data_req) begin
        unimpl_hit_q <= in_hole;
      end
    end
  end

  // ==========================================
  // answer stage
  // answer one cycle after the array, so the output is registered
  always @(posedge clk) begin
    if (rst) begin
      data_rdata_q <= 8'h00;
      data_valid_q <= 1'b0;
    end else begin
      // one answer per taken request, two edges after it
      data_valid_q <= pend_q;
      if (pend_q) begin
        // holes read zero
        // special area data is taken while its request stands
        if (sel_ram_q) begin
          data_rdata_q <= ram_rdata;
        end else if (sel_sfa_q) begin
          data_rdata_q <= sfa_rdata;
        end else begin
          data_rdata_q <= 8'h00;
        end
      end
    end
  end
endmodule

// >>> bench/mm_props.sv
// assertions on the memory decoder ports
`timescale 1ns/1ps
module mm_props (
  input wire clk, rst, pc_step, pc_load, intr_take, bank_select_bit, data_req,
  input wire [12:0] pc_load_value, pc_q,
  input wire [10:0] prog_addr_q,
  input wire [6:0] data_operand,
  input wire [7:0] data_rdata_q, sfa_addr_q,
  input wire data_valid_q, sfa_req_q, unimpl_hit_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [7:0] a = {bank_select_bit, data_operand};
  chk_pc_reset: assert property (disable iff (1'b0) rst |=> pc_q == 13'h0000)
    else $error("pc reset");
  chk_intr_vector: assert property (intr_take |=> pc_q == 13'h0004)
    else $error("intr vector");
  chk_pc_load: assert property (pc_load && !intr_take |=> pc_q == $past(pc_load_value))
    else $error("pc load");
  chk_pc_step: assert property (pc_step && !pc_load && !intr_take |=>
    pc_q == $past(pc_q) + 13'h0001) else $error("pc step");
  chk_prog_wrap: assert property (prog_addr_q == pc_q[10:0])
    else $error("prog wrap");
  chk_answer_lat: assert property (data_req |-> ##2 data_valid_q)
    else $error("answer late");
  chk_sfa_fwd: assert property (data_req && a[6:5] == 2'b00 |=>
    sfa_req_q && sfa_addr_q == $past(a)) else $error("sfa fwd");
  chk_ram_quiet: assert property (data_req && a[6:5] != 2'b00 |=> !sfa_req_q)
    else $error("ram to sfa");
  chk_hole_zero: assert property (data_req && a >= 8'hC0 && a <= 8'hEF |->
    ##2 data_rdata_q == 8'h00) else $error("hole read");
  chk_hole_flag: assert property (data_req |=>
    unimpl_hit_q == ($past(a) >= 8'hC0 && $past(a) <= 8'hEF)) else $error("hole flag");
endmodule
bind mcu_memory_map_decode mm_props i_props (.*);

// >>> bench/sfa_model.sv
// special function area stand-in
`timescale 1ns/1ps
module sfa_model (
  input wire clk, sfa_req_q, sfa_we_q,
  input wire [7:0] sfa_addr_q, sfa_wdata_q,
  output logic [7:0] sfa_rdata
);
  logic [7:0] regs [0:255];
  always @(posedge clk) begin
    if (sfa_req_q && sfa_we_q) regs[sfa_addr_q] <= sfa_wdata_q;
  end
  // answer while the request stands; a write answers with its own byte
  // released bus shows the inverse so stale data never matches
  always_comb begin
    if (sfa_req_q && sfa_we_q) sfa_rdata = sfa_wdata_q;
    else if (sfa_req_q) sfa_rdata = regs[sfa_addr_q];
    else sfa_rdata = ~regs[sfa_addr_q];
  end
endmodule

// >>> bench/testbench.sv
// random bench for the memory decoder
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, pc_step = 0, pc_load = 0, intr_take = 0;
  logic bank_select_bit = 0, data_req = 0, data_we = 0;
  logic [12:0] pc_load_value = 0, pc_q;
  logic [6:0] data_operand = 0;
  logic [7:0] data_wdata = 0, data_rdata_q, sfa_rdata, sfa_addr_q, sfa_wdata_q;
  logic [10:0] prog_addr_q;
  logic data_valid_q, sfa_req_q, sfa_we_q, unimpl_hit_q;
  integer num_errors = 0, checks = 0, seed = 50, pc = 0, i, x, n, y;
  integer m [0:511];
  integer q [$];
  always #4 clk = ~clk;
  mcu_memory_map_decode i_dut (.*, .upper_bank_bit_reserved(1'b0),
    .indirect_bank_bit_reserved(1'b0));
  sfa_model i_sfa (.*);
  function integer idx(input [7:0] a);
    if (a[6:5] == 0) idx = 256 + a;
    else if (a >= 8'hC0 && a < 8'hF0) idx = 511;
    else if (a >= 8'hF0) idx = a - 128;
    else idx = a;
  endfunction
  task chk(input [12:0] got, exp);
    checks++;
    if (got !== exp || ^got === 1'bx) begin
      num_errors++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (!rst) begin
      chk(pc_q, pc[12:0]);
      chk(prog_addr_q, pc[10:0]);
      if (data_valid_q) begin
        x = q.pop_front();
        chk(data_rdata_q, x[7:0]);
      end
    end
    if (rst) pc = 0;
    else if (intr_take) pc = 4;
    else if (pc_load) pc = pc_load_value;
    else if (pc_step) pc = (pc + 1) % 8192;
    if (!rst && data_req) begin
      i = idx({bank_select_bit, data_operand});
      if (data_we && i != 511) m[i] = data_wdata;
      q.push_back(m[i]);
    end
  end
  initial begin
    m[511] = 0;
    repeat (20) @(posedge clk);
    rst <= 0;
    for (n = 0; n < 2256; n++) begin
      @(posedge clk);
      y = $random(seed);
      {bank_select_bit, data_operand} <= n < 256 ? n : y;
      data_req <= n < 256 || y[8];
      data_we <= n < 256 || y[9];
      data_wdata <= y[23:16];
      {intr_take, pc_load, pc_step} <= {y[10] & y[11] & y[12], y[13] & y[14], y[15]};
      pc_load_value <= y[18] ? 13'h1FFF : y[31:19];
    end
    @(posedge clk);
    data_req <= 0;
    repeat (4) @(posedge clk);
    chk(q.size(), 0);
    summarize();
  end
  initial begin
    #40000;
    num_errors++;
    summarize();
  end
endmodule
